// ===== ast_pkg.sv
// constants and carrier types for the status, supply and temperature control registers
package ast_pkg;

	// register indices; the byte address is four times the index
	localparam logic [9:0]  IDX_STATUS_BACKUP = 10'h311;
	localparam logic [9:0]  IDX_SUPPLY_STATUS = 10'h312;
	localparam logic [9:0]  IDX_SOFT_RESET    = 10'h322;
	localparam logic [9:0]  IDX_TEMP_CONFIG   = 10'h323;

	// key that triggers a full front-end reset
	localparam logic [31:0] SOFT_RESET_KEY    = 32'h81000000;

	// reset values
	localparam logic [31:0] TEMP_CONFIG_RESET = 32'h00000000;
	localparam logic [8:0]  BACKUP_RESET      = 9'h000;
	localparam logic [31:0] READ_ZERO         = 32'h00000000;

	// temperature configuration field positions
	localparam int          TEMP_PERIOD_LSB   = 2;
	localparam int          TEMP_PERIOD_MSB   = 3;
	localparam int          TEMP_SYS_BIT      = 4;
	localparam int          TEMP_CFG_MSB      = 4;

	// measurement period codes
	localparam logic [1:0]  PERIOD_PER_ACCUM  = 2'h1;
	localparam logic [1:0]  PERIOD_CONTINUOUS = 2'h2;

	// supply status codes
	localparam logic [1:0]  SUPPLY_OK         = 2'h0;
	localparam logic [1:0]  SUPPLY_LOW        = 2'h1;
	localparam logic [1:0]  SUPPLY_FAIL       = 2'h3;

	// status-backup word layout
	localparam int          BACKUP_FLAG_LSB   = 0;
	localparam int          BACKUP_RESET_BIT  = 8;
	localparam int          MIRROR_FLAG_LSB   = 16;
	localparam int          MIRROR_RESET_BIT  = 24;

	// register access request from the serial slave port, one word per access
	typedef struct packed {
		logic [9:0]  addr;
		logic        wr;
		logic        rd;
		logic [31:0] wdata;
	} ast_req_type;

	// flags of the primary status word that the backup copies
	typedef struct packed {
		logic       after_reset;
		logic       engine_pass;
		logic       data_ready;
		logic [3:0] pulse_start;
	} ast_flags_type;

endpackage

// ===== ast_supply_monitor.sv
// supply comparator synchroniser and voltage status encoder
`timescale 1ns/1ps
`default_nettype none

module ast_supply_monitor
	import ast_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] supply_cmp,
	output logic      [1:0] supply_code
);

	logic [1:0] cmp_meta;
	logic [1:0] cmp_sync;
	wire  [1:0] next_supply_code;

	// two flops per comparator; the comparators are asynchronous to clk
	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cmp_meta[b] <= 1'b0;
					cmp_sync[b] <= 1'b0;
				end else begin
					cmp_meta[b] <= supply_cmp[b];
					cmp_sync[b] <= cmp_meta[b];
				end
			end
		end
	endgenerate

	// supply code mapping
	// bit 1 is above 3.0 V, bit 0 above 2.8 V; bit 1 alone wins, so a broken pair reads ok
	assign next_supply_code = cmp_sync[1] ? SUPPLY_OK :
	                          cmp_sync[0] ? SUPPLY_LOW : SUPPLY_FAIL;

	// registered status; reset shows fail until the comparators settle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			supply_code <= SUPPLY_FAIL;
		end else begin
			supply_code <= next_supply_code;
		end
	end

	supply_ok_a: assert property (@(posedge clk) disable iff (rst)
		cmp_sync[1] |=> supply_code == SUPPLY_OK)
		else $error("supply code not ok above upper threshold");

	supply_low_a: assert property (@(posedge clk) disable iff (rst)
		(!cmp_sync[1] && cmp_sync[0]) |=> supply_code == SUPPLY_LOW)
		else $error("supply code not low between thresholds");

	supply_fail_a: assert property (@(posedge clk) disable iff (rst)
		(!cmp_sync[1] && !cmp_sync[0]) |=> supply_code == SUPPLY_FAIL)
		else $error("supply code not fail below lower threshold");

endmodule

`default_nettype wire

// ===== ast_regs.sv
// status backup, supply status, soft reset and temperature configuration registers
// What this block does
// - supply status bits 1:0 read 00 above 3.0 V, 01 between, 11 below 2.8 V.
// - writing key 0x81000000 to the reset register performs a full front-end reset.
// - period field 01 measures each accumulation cycle, 10 measures continuously.
// - any other period code stops automatic temperature measurements.
// - supply-measure bit 4 adds a system supply measurement to each temperature cycle.
// - backup word copies the primary status word whenever the host reads it.
// - backup bits 0-3 pulse starts, 4 data ready, 5 engine pass, 8 reset.
`timescale 1ns/1ps
`default_nettype none

module ast_regs
	import ast_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire ast_req_type   req,
	output logic        [31:0] rdata,
	input  wire logic   [1:0]  supply_cmp,
	input  wire ast_flags_type primary_flags,
	input  wire logic          primary_read,
	input  wire logic          accum_cycle_done,
	input  wire logic          temp_busy,
	output logic               temp_measure_req,
	output logic               sys_supply_measure_req,
	output logic        [1:0]  temp_period,
	output logic               front_end_reset
);

	logic [TEMP_CFG_MSB:0] temp_config;
	logic [8:0]            backup_flags;
	logic [1:0]            supply_code;

	// comparator pins are synchronised and encoded in the monitor
	ast_supply_monitor u_supply (
		.clk         (clk),
		.rst         (rst),
		.supply_cmp  (supply_cmp),
		.supply_code (supply_code)
	);

	// address decode
	wire hit_backup = (req.addr == IDX_STATUS_BACKUP);
	wire hit_supply = (req.addr == IDX_SUPPLY_STATUS);
	wire hit_reset  = (req.addr == IDX_SOFT_RESET);
	wire hit_temp   = (req.addr == IDX_TEMP_CONFIG);

	// key must match exactly; any other value is ignored
	wire key_write  = req.wr && hit_reset && (req.wdata == SOFT_RESET_KEY);
	wire temp_write = req.wr && hit_temp;

	// high half mirrors the low flags, reserved bits zero
	wire [31:0] backup_word = {7'h00, backup_flags[BACKUP_RESET_BIT], 2'h0,
	                           backup_flags[5:0], 7'h00, backup_flags};

	// config fields
	wire [1:0] period_code = temp_config[TEMP_PERIOD_MSB:TEMP_PERIOD_LSB];
	wire       sys_measure = temp_config[TEMP_SYS_BIT];

	// request on accumulation end, or whenever idle in continuous mode
	// other codes fall through to no request
	wire next_temp_req = (period_code == PERIOD_PER_ACCUM) ? accum_cycle_done :
	                     (period_code == PERIOD_CONTINUOUS) ? (!temp_busy && !temp_measure_req) :
	                     1'b0;

	// supply measurement rides along with each temperature request
	wire next_sys_req = next_temp_req && sys_measure;

	// flag order in the copy is pulses, data ready, engine pass, reset
	wire [8:0] primary_copy = {primary_flags.after_reset, 2'h0, primary_flags.engine_pass,
	                           primary_flags.data_ready, primary_flags.pulse_start};

	// read mux; write-only and unmapped words read as zero
	wire [31:0] next_rdata = hit_backup ? backup_word :
	                         hit_supply ? {30'h0, supply_code} :
	                         hit_temp   ? {27'h0000000, temp_config} :
	                         READ_ZERO;

	// soft reset clears the configuration; only bits 4:2 are stored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			temp_config <= TEMP_CONFIG_RESET[TEMP_CFG_MSB:0];
		end else if (key_write) begin
			temp_config <= TEMP_CONFIG_RESET[TEMP_CFG_MSB:0];
		end else if (temp_write) begin
			temp_config <= {req.wdata[TEMP_CFG_MSB:TEMP_PERIOD_LSB], 2'h0};
		end
	end

	// capture on primary read; soft reset takes priority
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			backup_flags <= BACKUP_RESET;
		end else if (key_write) begin
			backup_flags <= BACKUP_RESET;
		end else if (primary_read) begin
			backup_flags <= primary_copy;
		end
	end

	// measurement requests and the reset strobe are one-cycle pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			temp_measure_req       <= 1'b0;
			sys_supply_measure_req <= 1'b0;
			front_end_reset        <= 1'b0;
		end else begin
			temp_measure_req       <= next_temp_req && !key_write;
			sys_supply_measure_req <= next_sys_req && !key_write;
			front_end_reset        <= key_write;
		end
	end

	// read data holds until the next read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= READ_ZERO;
		end else if (req.rd) begin
			rdata <= next_rdata;
		end
	end

	assign temp_period = period_code;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence seq_key_write;
		req.wr && (req.addr == IDX_SOFT_RESET) && (req.wdata == SOFT_RESET_KEY);
	endsequence

	sequence seq_backup_read;
		req.rd && (req.addr == IDX_STATUS_BACKUP);
	endsequence

	sequence seq_temp_read;
		req.rd && (req.addr == IDX_TEMP_CONFIG);
	endsequence

	sequence seq_supply_read;
		req.rd && (req.addr == IDX_SUPPLY_STATUS);
	endsequence

	sequence seq_temp_write;
		req.wr && (req.addr == IDX_TEMP_CONFIG);
	endsequence

	soft_reset_fire_a: assert property (seq_key_write |=> front_end_reset
		&& temp_config == 5'h00 && backup_flags == 9'h000)
		else $error("key write did not reset the front end");

	soft_reset_key_a: assert property (front_end_reset |-> $past(key_write))
		else $error("front-end reset without the key value");

	per_accum_req_a: assert property (($past(period_code) == 2'h1 && $past(accum_cycle_done)
		&& !$past(key_write)) |-> temp_measure_req)
		else $error("no request at accumulation end");

	continuous_req_a: assert property ((period_code == 2'h2 && !temp_busy
		&& !temp_measure_req && !key_write) |=> temp_measure_req)
		else $error("continuous mode did not request");

	no_auto_update_a: assert property ((period_code == 2'h0 || period_code == 2'h3)
		|=> !temp_measure_req)
		else $error("request with automatic updates disabled");

	sys_supply_req_a: assert property (sys_supply_measure_req
		|-> temp_measure_req && $past(temp_config[4]))
		else $error("supply measurement outside a temperature cycle");

	backup_mirror_a: assert property (seq_backup_read |=> rdata[21:16] == rdata[5:0]
		&& rdata[24] == rdata[8] && rdata[15:9] == 7'h00 && rdata[7:6] == 2'h0
		&& rdata[23:22] == 2'h0 && rdata[31:25] == 7'h00)
		else $error("backup mirror bits wrong");

	backup_capture_a: assert property ((primary_read && !key_write)
		|=> backup_flags == {$past(primary_flags.after_reset), 2'h0,
		$past(primary_flags.engine_pass), $past(primary_flags.data_ready),
		$past(primary_flags.pulse_start)})
		else $error("backup did not capture primary status");

	backup_read_a: assert property (seq_backup_read |=> rdata[5:0] == $past(backup_flags[5:0])
		&& rdata[8] == $past(backup_flags[8]))
		else $error("backup read returned wrong flags");

	// register reads: reserved bits stay zero, fields come from the stored state
	temp_read_a: assert property (seq_temp_read |=> rdata[31:5] == 27'h0000000
		&& rdata[1:0] == 2'h0
		&& rdata[4:2] == $past(temp_config[TEMP_CFG_MSB:TEMP_PERIOD_LSB]))
		else $error("config read returned wrong bits");

	supply_read_a: assert property (seq_supply_read |=> rdata[31:2] == 30'h0
		&& rdata[1:0] == $past(supply_code))
		else $error("supply read returned wrong code");

	// a config write keeps bits 4:2 and drops the reserved bits
	temp_write_a: assert property (seq_temp_write |=> temp_config
		== {$past(req.wdata[TEMP_CFG_MSB:TEMP_PERIOD_LSB]), 2'h0})
		else $error("config write not stored");

	// any value other than the key leaves the front end alone
	key_refused_a: assert property ((req.wr && hit_reset
		&& req.wdata != SOFT_RESET_KEY) |=> !front_end_reset)
		else $error("reset fired on a wrong key");

	key_no_req_a: assert property (seq_key_write |=> !temp_measure_req
		&& !sys_supply_measure_req)
		else $error("measurement requested during soft reset");

	// requests only on their trigger, never two in a row in continuous mode
	per_accum_only_a: assert property ((period_code == PERIOD_PER_ACCUM
		&& !accum_cycle_done) |=> !temp_measure_req)
		else $error("request without accumulation end");

	continuous_gap_a: assert property ((period_code == PERIOD_CONTINUOUS
		&& temp_measure_req) |=> !temp_measure_req)
		else $error("back-to-back continuous requests");

	sys_supply_pair_a: assert property ((temp_measure_req
		&& $past(sys_measure)) |-> sys_supply_measure_req)
		else $error("supply measurement missing from temperature cycle");

	// backup moves only on a primary read or a soft reset; bus writes are ignored
	backup_hold_a: assert property ((!primary_read && !key_write)
		|=> $stable(backup_flags))
		else $error("backup changed without a primary read");

endmodule

`default_nettype wire

// ===== ast_temp_model.sv
// temperature subsystem stand-in that answers start requests with a busy span
`timescale 1ns/1ps
`default_nettype none

module ast_temp_model
	import ast_pkg::*;
#(
	parameter int BUSY_CYCLES = 4
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic temp_measure_req,
	output logic      temp_busy
);
	int left;

	// busy rises the cycle after a start, so continuous mode must wait it out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left <= 0;
		end else if (temp_measure_req) begin
			left <= BUSY_CYCLES;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
	assign temp_busy = (left > 0);
endmodule

`default_nettype wire

// ===== test_afe_status_temp_control_regs.sv
// self-checking testbench for the status, supply and temperature control registers
`timescale 1ns/1ps
`default_nettype none

module test_afe_status_temp_control_regs
	import ast_pkg::*;
;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	ast_req_type   req = '0;
	logic [31:0]   rdata;
	logic [1:0]    supply_cmp = 2'h3;
	ast_flags_type flags = '0;
	logic          prd = 1'b0;
	logic          accum = 1'b0;
	logic          busy;
	logic          tmr;
	logic          sysr;
	logic [1:0]    per;
	logic          fer;
	int            bad_count = 0;
	int            checks = 0;
	int            n_req = 0;
	int            n_sys = 0;
	int            n_fer = 0;
	logic [1:0]    cmp_tab [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
	logic [1:0]    code_tab [4] = '{SUPPLY_OK, SUPPLY_LOW, SUPPLY_FAIL, SUPPLY_OK};

	ast_regs DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .supply_cmp(supply_cmp),
		.primary_flags(flags), .primary_read(prd), .accum_cycle_done(accum),
		.temp_busy(busy), .temp_measure_req(tmr), .sys_supply_measure_req(sysr),
		.temp_period(per), .front_end_reset(fer));
	ast_temp_model temp (.clk(clk), .rst(rst), .temp_measure_req(tmr), .temp_busy(busy));

	initial begin
		forever #20 clk = ~clk;
	end

	// pulses last one cycle, so they are counted at every rising edge
	always @(posedge clk) begin
		n_req += int'(tmr === 1'b1);
		n_sys += int'(sysr === 1'b1);
		n_fer += int'(fer === 1'b1);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(negedge clk);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge clk);
		req.wr = 1'b0;
	endtask

	// read data is registered, so it is looked at one cycle after the strobe
	task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
		@(negedge clk);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clk);
		req.rd = 1'b0;
		check(rdata, exp);
	endtask

	task automatic pulse_accum(input int n);
		repeat (n) begin
			@(negedge clk);
			accum = 1'b1;
			@(negedge clk);
			accum = 1'b0;
			repeat (6) @(negedge clk);
		end
	endtask

	task automatic capture(input ast_flags_type f);
		@(negedge clk);
		flags = f;
		prd = 1'b1;
		@(negedge clk);
		prd = 1'b0;
	endtask

	task automatic close_out;
		$display("checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#(40 * 5000);
		bad_count++;
		close_out();
	end

	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rchk(IDX_TEMP_CONFIG, TEMP_CONFIG_RESET);
		rchk(IDX_STATUS_BACKUP, READ_ZERO);
		rchk(10'h300, READ_ZERO);
		$display("test reset values done");
		// the last pair has only the upper comparator set, which reads as ok
		for (int i = 0; i < 4; i++) begin
			supply_cmp = cmp_tab[i];
			repeat (4) @(negedge clk);
			rchk(IDX_SUPPLY_STATUS, {30'h0, code_tab[i]});
		end
		wr(IDX_SUPPLY_STATUS, 32'hFFFFFFFF);
		rchk(IDX_SUPPLY_STATUS, {30'h0, SUPPLY_OK});
		$display("test supply status done");
		// period codes 11 and 00 must never start a measurement
		foreach (code_tab[i]) begin
			wr(IDX_TEMP_CONFIG, (i == 0) ? 32'hFFFFFFFF : 32'h00000010);
			n_req = 0;
			pulse_accum(3);
			check(n_req, 0);
			check({31'h0, tmr}, 32'h0);
		end
		check({30'h0, per}, 32'h0);
		wr(IDX_TEMP_CONFIG, 32'h00000014);
		rchk(IDX_TEMP_CONFIG, 32'h00000014);
		check({30'h0, per}, {30'h0, PERIOD_PER_ACCUM});
		n_req = 0;
		n_sys = 0;
		pulse_accum(3);
		check(n_req, 3);
		check(n_sys, 3);
		wr(IDX_TEMP_CONFIG, 32'h00000008);
		n_req = 0;
		n_sys = 0;
		repeat (40) @(negedge clk);
		check({31'h0, n_req >= 5}, 32'h1);
		check(n_sys, 0);
		wr(IDX_TEMP_CONFIG, 32'h00000000);
		$display("test temperature config done");
		capture(7'h55);
		rchk(IDX_STATUS_BACKUP, 32'h01150115);
		flags = 7'h2A;
		rchk(IDX_STATUS_BACKUP, 32'h01150115);
		wr(IDX_STATUS_BACKUP, 32'h0);
		capture(7'h2A);
		rchk(IDX_STATUS_BACKUP, 32'h002A002A);
		$display("test status backup done");
		wr(IDX_TEMP_CONFIG, 32'h00000014);
		n_fer = 0;
		wr(IDX_SOFT_RESET, 32'h81000001);
		// the reset pulse is counted one edge after the write lands
		@(negedge clk);
		check(n_fer, 0);
		rchk(IDX_TEMP_CONFIG, 32'h00000014);
		wr(IDX_SOFT_RESET, SOFT_RESET_KEY);
		@(negedge clk);
		check(n_fer, 1);
		rchk(IDX_TEMP_CONFIG, 32'h0);
		rchk(IDX_STATUS_BACKUP, 32'h0);
		$display("test soft reset done");
		close_out();
	end
endmodule

`default_nettype wire
